// >>> logic/ofrr_consts.vh
`ifndef OFRR_CONSTS_VH
`define OFRR_CONSTS_VH
`define OFRR_ADDR_CH0 8'h1D
`define OFRR_ADDR_CH1 8'h1E
`define OFRR_ADDR_CH2 8'h1F
`define OFRR_ADDR_CH3 8'h20
`define OFRR_ADDR_CH4 8'h21
`define OFRR_ADDR_CH5 8'h22
`define OFRR_NUM_CH 6
`define OFRR_SEL_MSB 3
`define OFRR_SEL_LSB 0
`define OFRR_RSV_MSB 7
`define OFRR_RSV_LSB 4
`define OFRR_RESET_BYTE 8'h00
`define OFRR_RESET_SEL 4'h0
`define OFRR_CODE_60R 4'h0
`define OFRR_CODE_5K6 4'h5
`define OFRR_CODE_11K2 4'h6
`define OFRR_CODE_22K2 4'h7
`define OFRR_CODE_44K4 4'h8
`define OFRR_CODE_104K 4'h9
`define OFRR_TAP_60R 6'h01
`define OFRR_TAP_5K6 6'h02
`define OFRR_TAP_11K2 6'h04
`define OFRR_TAP_22K2 6'h08
`define OFRR_TAP_44K4 6'h10
`define OFRR_TAP_104K 6'h20
`endif

// >>> logic/ofrr_channel.v
`timescale 1ns/10ps
`include "ofrr_consts.vh"
module ofrr_channel (
    // Clock and reset
    input wire clk,
    input wire nrst,
    // Write port for this channel only
    input wire wr_en,
    input wire [3:0] wr_code,
    // Held selection
    output reg [3:0] sel_reg,
    output reg [5:0] tap_reg
);
    function valid_code;
        input [3:0] c;
        begin
            valid_code = (c == `OFRR_CODE_60R) || (c == `OFRR_CODE_5K6) ||
                (c == `OFRR_CODE_11K2) || (c == `OFRR_CODE_22K2) ||
                (c == `OFRR_CODE_44K4) || (c == `OFRR_CODE_104K);
        end
    endfunction

    function [5:0] tap_of;
        input [3:0] c;
        begin
            case (c)
                `OFRR_CODE_60R: tap_of = `OFRR_TAP_60R; // [RL2]
                `OFRR_CODE_5K6: tap_of = `OFRR_TAP_5K6; // [RL2]
                `OFRR_CODE_11K2: tap_of = `OFRR_TAP_11K2; // [RL2]
                `OFRR_CODE_22K2: tap_of = `OFRR_TAP_22K2; // [RL2]
                `OFRR_CODE_44K4: tap_of = `OFRR_TAP_44K4; // [RL2]
                `OFRR_CODE_104K: tap_of = `OFRR_TAP_104K; // [RL2]
                default: tap_of = `OFRR_TAP_60R;
            endcase
        end
    endfunction

    // Unlisted codes keep the previous resistor so no undefined tap is
    // ever switched onto the output.
    always @(posedge clk)
    begin
        if (!nrst)
        begin
            sel_reg <= `OFRR_RESET_SEL; // [RL1] [RL6]
            tap_reg <= `OFRR_TAP_60R; // [RL6]
        end
        else if (wr_en && valid_code(wr_code)) // [RL9]
        begin
            sel_reg <= wr_code; // [RL1]
            tap_reg <= tap_of(wr_code); // [RL2] [RL3]
        end
    end
endmodule // ofrr_channel

// >>> logic/ofrr_top.v
// How it works
// [RL1] Each channel has a read/write 4-bit resistor select, reset to zero.
// [RL2] Codes 0,5,6,7,8,9 select 60R,5.6k,11.2k,22.2k,44.4k,104k.
// [RL3] The chosen resistor pairs with that channel's damping capacitor.
// [RL4] A write changes only the addressed channel's selection.
// [RL5] Channels one to five sit at 0x1E through 0x22.
// [RL6] Every filter register resets to zero, selecting 60 ohm.
// [RL7] Upper nibble is reserved, reads zero, ignores writes.
// [RL8] Channel zero sits at 0x1D, resetting to zero.
// [RL9] Host writes only listed codes; others keep the previous selection.
`timescale 1ns/10ps
`include "ofrr_consts.vh"
module ofrr_top (
    // Clock and reset
    input wire CLK,
    input wire NRST,
    // Register access from the serial interface
    input wire REG_WR,
    input wire REG_RD,
    input wire [7:0] REG_ADDR,
    input wire [7:0] REG_WDATA,
    output reg [7:0] REG_RDATA,
    output reg REG_HIT,
    // Resistor taps, one-hot, per channel
    output reg [5:0] RES_SEL_CH0,
    output reg [5:0] RES_SEL_CH1,
    output reg [5:0] RES_SEL_CH2,
    output reg [5:0] RES_SEL_CH3,
    output reg [5:0] RES_SEL_CH4,
    output reg [5:0] RES_SEL_CH5
);
    wire [3:0] sel [0:5];
    wire [5:0] tap [0:5];
    reg [7:0] rdata_next;
    reg hit_next;
    integer k;

    function [2:0] ch_of;
        input [7:0] a;
        begin
            case (a)
                `OFRR_ADDR_CH0: ch_of = 3'h0; // [RL8]
                `OFRR_ADDR_CH1: ch_of = 3'h1; // [RL5]
                `OFRR_ADDR_CH2: ch_of = 3'h2; // [RL5]
                `OFRR_ADDR_CH3: ch_of = 3'h3; // [RL5]
                `OFRR_ADDR_CH4: ch_of = 3'h4; // [RL5]
                `OFRR_ADDR_CH5: ch_of = 3'h5; // [RL5]
                default: ch_of = 3'h7;
            endcase
        end
    endfunction

    genvar g;
    generate
        for (g = 0; g < `OFRR_NUM_CH; g = g + 1)
        begin : chan
            localparam [2:0] CH_IDX = g;
            ofrr_channel u_ch (
                .clk(CLK),
                .nrst(NRST),
                .wr_en(REG_WR && (ch_of(REG_ADDR) == CH_IDX)), // [RL4]
                .wr_code(REG_WDATA[`OFRR_SEL_MSB:`OFRR_SEL_LSB]), // [RL7]
                .sel_reg(sel[g]),
                .tap_reg(tap[g])
            );
        end
    endgenerate

    always @*
    begin
        rdata_next = `OFRR_RESET_BYTE;
        hit_next = 1'b0;
        for (k = 0; k < `OFRR_NUM_CH; k = k + 1)
        begin
            if (ch_of(REG_ADDR) == k[2:0])
            begin
                rdata_next = {4'h0, sel[k]}; // [RL7]
                hit_next = 1'b1;
            end
        end
        if (!REG_RD)
        begin
            rdata_next = `OFRR_RESET_BYTE;
        end
    end

    // Outputs are registered; taps lag the select by one clock.
    always @(posedge CLK)
    begin
        if (!NRST)
        begin
            REG_RDATA <= `OFRR_RESET_BYTE;
            REG_HIT <= 1'b0;
            RES_SEL_CH0 <= `OFRR_TAP_60R; // [RL6]
            RES_SEL_CH1 <= `OFRR_TAP_60R;
            RES_SEL_CH2 <= `OFRR_TAP_60R;
            RES_SEL_CH3 <= `OFRR_TAP_60R;
            RES_SEL_CH4 <= `OFRR_TAP_60R;
            RES_SEL_CH5 <= `OFRR_TAP_60R;
        end
        else
        begin
            REG_RDATA <= rdata_next;
            REG_HIT <= hit_next && (REG_RD || REG_WR);
            RES_SEL_CH0 <= tap[0]; // [RL3]
            RES_SEL_CH1 <= tap[1]; // [RL3]
            RES_SEL_CH2 <= tap[2];
            RES_SEL_CH3 <= tap[3];
            RES_SEL_CH4 <= tap[4];
            RES_SEL_CH5 <= tap[5];
        end
    end
endmodule // ofrr_top

// >>> tb/ofrr_host.sv
`timescale 1ns/10ps
module ofrr_host (
    input wire clk,
    output reg wr = 0, rd = 0,
    output reg [7:0] addr = 0, wdata = 0,
    input wire [7:0] rdata,
    input wire hit
);
    // The device never stalls, so each strobe lasts exactly one cycle.
    task put(input [7:0] a, d);
        @(posedge clk);
        {wr, addr, wdata} <= {1'b1, a, d};
        @(posedge clk);
        wr <= 0;
    endtask
    task get(input [7:0] a, output [7:0] d, output h);
        @(posedge clk);
        {rd, addr} <= {1'b1, a};
        @(posedge clk);
        rd <= 0;
        // The answer stands for the cycle after the strobe edge.
        @(posedge clk);
        {d, h} = {rdata, hit};
    endtask
endmodule // ofrr_host

// >>> tb/ofrr_checker.sv
`timescale 1ns/10ps
module ofrr_checker (
    input wire CLK, NRST, REG_WR, REG_RD, REG_HIT,
    input wire [7:0] REG_ADDR, REG_WDATA, REG_RDATA,
    input wire [5:0] RES_SEL_CH0, RES_SEL_CH1, RES_SEL_CH2,
    input wire [5:0] RES_SEL_CH3, RES_SEL_CH4, RES_SEL_CH5
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!NRST);
    function [5:0] tap(input [3:0] c);
        tap = c == 0 ? 6'h01 : (c > 4 && c < 10) ? 6'h02 << (c - 5) : 6'h00;
    endfunction
    wire hit = REG_ADDR >= 8'h1D && REG_ADDR <= 8'h22;
    wire w0 = REG_WR && REG_ADDR == 8'h1D && tap(REG_WDATA[3:0]) != 0;
    a_rd_hit: assert property (REG_RD && hit |=> REG_HIT)
        else $error("no hit");
    a_unmap_zero: assert property
        (REG_RD && !hit |=> !REG_RDATA && !REG_HIT)
        else $error("unmapped read");
    a_rsv_zero: assert property (REG_RDATA[7:4] == 4'h0)
        else $error("reserved set");
    a_tap_onehot: assert property
        ($onehot(RES_SEL_CH0) && $onehot(RES_SEL_CH1) &&
        $onehot(RES_SEL_CH2) && $onehot(RES_SEL_CH3) &&
        $onehot(RES_SEL_CH4) && $onehot(RES_SEL_CH5))
        else $error("tap not one-hot");
    a_wr_tap: assert property
        (w0 |-> ##2 RES_SEL_CH0 == tap($past(REG_WDATA[3:0], 2)))
        else $error("tap wrong");
    a_others_held: assert property (!w0 |-> ##2 $stable(RES_SEL_CH0))
        else $error("tap moved");
    a_read_back: assert property (w0 ##1 !REG_WR ##1 REG_RD && REG_ADDR == 8'h1D
        && !REG_WR |=> REG_RDATA == $past(REG_WDATA[3:0], 3))
        else $error("read back");
    a_reset_val: assert property (@(posedge CLK) disable iff (1'b0) !NRST
        |=> RES_SEL_CH5 == 6'h01 && !REG_RDATA && !REG_HIT)
        else $error("reset value");
endmodule // ofrr_checker
bind ofrr_top ofrr_checker i_ofrr_checker (.*);

// >>> tb/test_ofrr_top.sv
`timescale 1ns/10ps
module test_ofrr_top;
    reg CLK = 0, NRST = 0, h, in_map;
    wire REG_WR, REG_RD, REG_HIT;
    wire [7:0] REG_ADDR, REG_WDATA, REG_RDATA;
    wire [5:0] RES_SEL_CH0, RES_SEL_CH1, RES_SEL_CH2;
    wire [5:0] RES_SEL_CH3, RES_SEL_CH4, RES_SEL_CH5;
    wire [35:0] taps = {RES_SEL_CH5, RES_SEL_CH4, RES_SEL_CH3,
        RES_SEL_CH2, RES_SEL_CH1, RES_SEL_CH0};
    integer n_mismatch = 0, checked = 0, i, k, x = 29521;
    integer m[6] = '{default: 0};
    byte cd[6] = '{0, 5, 6, 7, 8, 9};
    reg [7:0] a, d, g;
    always #20 CLK = ~CLK;
    ofrr_top i_ofrr_top (.*);
    ofrr_host i_ofrr_host (.clk(CLK), .wr(REG_WR), .rd(REG_RD),
        .addr(REG_ADDR), .wdata(REG_WDATA), .rdata(REG_RDATA), .hit(REG_HIT));
    function integer rnd();
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        x = x ^ (x << 5);
        return x;
    endfunction
    task ck(input [7:0] gv, ev);
        checked++;
        if (gv !== ev)
        begin
            n_mismatch++;
            $display("[ERR] %0t got %h want %h", $time, gv, ev);
        end
    endtask
    task test_done;
        $display("checked %0d n_mismatch %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task scan;
        for (k = 0; k < 6; k++)
        begin
            i_ofrr_host.get(8'h1D + k, g, h);
            ck(g, cd[m[k]]);
            ck(taps[6*k+:6], 6'h01 << m[k]);
        end
    endtask
    initial
    begin
        repeat (16) @(posedge CLK);
        NRST <= 1;
        scan;
        repeat (150)
        begin
            i = rnd();
            a = i[2:0] < 6 ? 8'h1D + i[2:0] : i[15:8];
            d = i[23:16];
            in_map = a >= 8'h1D && a <= 8'h22;
            i_ofrr_host.put(a, d);
            // Unlisted codes leave the selection as it was.
            for (k = 0; k < 6; k++)
                if (in_map && cd[k] == d[3:0])
                    m[a - 8'h1D] = k;
            i_ofrr_host.get(a, g, h);
            ck(h, in_map);
            ck(g, in_map ? cd[m[a - 8'h1D]] : 0);
            scan;
        end
        test_done;
    end
    initial
    begin
        #400000;
        n_mismatch++;
        test_done;
    end
endmodule // test_ofrr_top
